// ---- src/uep_ctrl.sv ----
// endpoint, address and upstream port registers behind the i/o port
`timescale 1ns/1ps
module uep_ctrl (
   input  wire logic        clk_sys,
   input  wire logic        srst,
   // processor i/o port
   input  wire logic [7:0]  io_addr,
   input  wire logic [7:0]  io_wdata,
   input  wire logic        port_read,
   input  wire logic        port_write,
   output logic [7:0]       io_rdata,
   // processor ram writes to be gated
   input  wire logic        ram_wr_req,
   input  wire logic [7:0]  ram_wr_addr,
   input  wire logic [7:0]  ram_wr_data,
   output logic             ram_wr_en,
   output logic [7:0]       ram_wr_addr_q,
   output logic [7:0]       ram_wr_data_q,
   // upstream pins
   input  wire logic        dp_i,
   input  wire logic        dm_i,
   output logic             dp_o,
   output logic             dp_oe,
   output logic             dm_o,
   output logic             dm_oe,
   // serial engine side
   input  wire logic        se_dp_o,
   input  wire logic        se_dm_o,
   input  wire logic        se_oe,
   input  wire logic        se_bus_activity,
   input  wire logic        se_setup_start,
   input  wire logic        se_ack_start,
   input  wire logic        se_ep0_rx_active,
   input  wire logic        se_txn_done,
   input  wire logic [2:0]  se_txn_ep,
   input  wire logic [1:0]  se_txn_pid,
   input  wire logic        se_txn_acked,
   input  wire logic [5:0]  se_rx_count,
   input  wire logic        se_rx_toggle,
   output logic             addr_match_en,
   output logic [6:0]       dev_addr,
   output logic [19:0]      ep_mode_flat,
   output logic [4:0]       ep_stall,
   output logic [4:0]       ep_toggle,
   output logic [39:0]      ep_fifo_base,
   output logic [4:0]       ep_fifo_active,
   output logic             line_dp,
   output logic             line_dm
);
   // returns {hit, index} for a mode register offset
   function automatic logic [3:0] mode_slot(input logic [7:0] a);
      case (a)
         uep_pkg::ADDR_MODE_A: mode_slot = 4'h8;
         uep_pkg::ADDR_MODE_B: mode_slot = 4'h9;
         uep_pkg::ADDR_MODE_C: mode_slot = 4'hA;
         uep_pkg::ADDR_MODE_D: mode_slot = 4'hB;
         uep_pkg::ADDR_MODE_E: mode_slot = 4'hC;
         default:              mode_slot = 4'h0;
      endcase
   endfunction

   // returns {hit, index} for a count register offset
   function automatic logic [3:0] count_slot(input logic [7:0] a);
      case (a)
         uep_pkg::ADDR_COUNT_A: count_slot = 4'h8;
         uep_pkg::ADDR_COUNT_B: count_slot = 4'h9;
         uep_pkg::ADDR_COUNT_C: count_slot = 4'hA;
         uep_pkg::ADDR_COUNT_D: count_slot = 4'hB;
         uep_pkg::ADDR_COUNT_E: count_slot = 4'hC;
         default:               count_slot = 4'h0;
      endcase
   endfunction

   // upstream port register state
   logic       up_size, next_up_size;      // fifo size layout
   logic       up_five, next_up_five;      // five endpoints
   logic       up_act, next_up_act;        // sticky bus activity
   logic [2:0] up_ctrl, next_up_ctrl;      // line forcing code
   // device address register
   logic       addr_en, next_addr_en;
   logic [6:0] addr_val, next_addr_val;
   // endpoint registers, indexed by endpoint number
   logic [3:0] mode [5];
   logic [3:0] next_mode [5];
   logic [4:0] ack, next_ack;
   logic [4:0] stall, next_stall;         // unused for endpoint 0
   logic [7:0] cnt [5];
   logic [7:0] next_cnt [5];
   // endpoint 0 token flags {setup, in, out}
   logic [2:0] tok, next_tok;
   logic       ep0_lock, next_ep0_lock;    // low seven bits locked
   logic       setup_busy, next_setup_busy;   // data phase to ack
   logic       setup_block, next_setup_block; // no clear until read
   // port read data and ram gate
   logic [7:0] next_rdata;
   logic       next_ram_en;
   logic       in_ep0_buf;                 // ram address inside ep0 fifo
   // pin synchronisers
   logic       dp_meta, dm_meta;
   logic [3:0] ms, cs;
   logic [2:0] ev_ep;
   logic       ev_ok;

   // line drive and fifo map
   uep_line_drive u_drive (
      .clk_sys    (clk_sys),
      .srst       (srst),
      .force_code (up_ctrl),
      .se_dp_o    (se_dp_o),
      .se_dm_o    (se_dm_o),
      .se_oe      (se_oe),
      .dp_o       (dp_o),
      .dp_oe      (dp_oe),
      .dm_o       (dm_o),
      .dm_oe      (dm_oe)
   );

   uep_fifo_map u_map (
      .clk_sys     (clk_sys),
      .srst        (srst),
      .size_sel    (up_size),
      .five_sel    (up_five),
      .fifo_base   (ep_fifo_base),
      .fifo_active (ep_fifo_active)
   );

   // flat views of endpoint flops for the engine
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         ep_mode_flat[4*i +: 4] = mode[i];
         ep_toggle[i]           = cnt[i][7];
      end
      ep_stall = {stall[4:1], 1'b0};
   end

   // ep0 buffer hit uses the registered layout base
   assign in_ep0_buf = (ram_wr_addr[7:3] == ep_fifo_base[7:3]);

   // next values of all registers
   always_comb begin
      next_up_size     = up_size;
      next_up_five     = up_five;
      next_up_act      = up_act;
      next_up_ctrl     = up_ctrl;
      next_addr_en     = addr_en;
      next_addr_val    = addr_val;
      next_mode        = mode;
      next_ack         = ack;
      next_stall       = stall;
      next_cnt         = cnt;
      next_tok         = tok;
      next_ep0_lock    = ep0_lock;
      next_setup_busy  = setup_busy;
      next_setup_block = setup_block;
      next_rdata       = io_rdata;
      ms               = mode_slot(io_addr);
      cs               = count_slot(io_addr);
      ev_ep            = se_txn_ep;
      // endpoints three and four exist only in five mode
      ev_ok = se_txn_done && (ev_ep < 3'h3 || (up_five && ev_ep < 3'h5));

      // processor writes
      if (port_write) begin
         if (io_addr == uep_pkg::ADDR_UPSTREAM) begin
            next_up_size = io_wdata[uep_pkg::UP_SIZE_BIT];
            next_up_five = io_wdata[uep_pkg::UP_FIVE_BIT];
            if (!io_wdata[uep_pkg::UP_ACT_BIT]) begin
               next_up_act = 1'b0;
            end
            next_up_ctrl = io_wdata[2:0];
         end
         if (io_addr == uep_pkg::ADDR_FUNC_ADDR) begin
            next_addr_en  = io_wdata[7];
            next_addr_val = io_wdata[6:0];
         end
         if (cs[3]) begin
            next_cnt[cs[2:0]] = io_wdata;
         end
         if (ms[3] && ms[2:0] == 3'h0) begin
            // setup flag survives until the first read after the ack starts
            if (!setup_block) begin
               next_tok[2] = io_wdata[7];
            end
            if (!ep0_lock) begin
               next_tok[1:0] = io_wdata[6:5];
               next_ack[0]   = io_wdata[uep_pkg::MD_ACK_BIT];
               next_mode[0]  = io_wdata[3:0];
            end
         end else if (ms[3]) begin
            next_stall[ms[2:0]] = io_wdata[uep_pkg::MD_TOP_BIT];
            next_ack[ms[2:0]]   = io_wdata[uep_pkg::MD_ACK_BIT];
            next_mode[ms[2:0]]  = io_wdata[3:0];
         end
      end

      // processor reads; unmapped offsets read zero
      if (port_read) begin
         next_rdata = 8'h00;
         if (io_addr == uep_pkg::ADDR_UPSTREAM) begin
            next_rdata = {up_size, up_five, line_dp, line_dm, up_act, up_ctrl};
         end
         if (io_addr == uep_pkg::ADDR_FUNC_ADDR) begin
            next_rdata = {addr_en, addr_val};
         end
         if (cs[3]) begin
            next_rdata = cnt[cs[2:0]];
         end
         if (ms[3] && ms[2:0] == 3'h0) begin
            next_rdata = {tok, ack[0], mode[0]};
            // read unlocks; a same-cycle engine update relocks below
            next_ep0_lock = 1'b0;
            if (!setup_busy) begin
               next_setup_block = 1'b0;
            end
         end else if (ms[3]) begin
            next_rdata = {stall[ms[2:0]], 2'h0, ack[ms[2:0]], mode[ms[2:0]]};
         end
      end

      // engine events come last so a set beats a clear
      if (se_bus_activity) begin
         next_up_act = 1'b1;
      end
      if (se_setup_start) begin
         next_tok[2]      = 1'b1;
         next_setup_busy  = 1'b1;
         next_setup_block = 1'b1;
      end
      if (se_ack_start) begin
         next_setup_busy = 1'b0;
      end
      if (ev_ok) begin
         if (ev_ep == 3'h0) begin
            if (se_txn_pid == uep_pkg::PID_IN) begin
               next_tok[1] = 1'b1;
            end
            if (se_txn_pid == uep_pkg::PID_OUT) begin
               next_tok[0] = 1'b1;
            end
            next_ep0_lock = 1'b1;
         end
         if (se_txn_acked) begin
            next_ack[ev_ep] = 1'b1;
         end
         if (se_txn_pid == uep_pkg::PID_SETUP &&
             mode[ev_ep] != uep_pkg::MODE_DISABLE) begin
            next_mode[ev_ep] = uep_pkg::MODE_NAK_BOTH;
         end else if (se_txn_acked && mode[ev_ep][3] && mode[ev_ep][0]) begin
            next_mode[ev_ep] = {mode[ev_ep][3:1], 1'b0};
         end
         if (se_txn_acked && se_txn_pid != uep_pkg::PID_IN) begin
            next_cnt[ev_ep] = {se_rx_toggle, 1'b1, se_rx_count};
         end
      end

      // ep0 buffer is untouchable while receiving or after setup
      next_ram_en = ram_wr_req &&
                    !(in_ep0_buf && (se_ep0_rx_active || tok[2]));
   end

   // register everything
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         // fields sit at bits 7, 6 and 3:0; the line bits 5:4 hold no state
         {up_size, up_five, up_act, up_ctrl} <= {uep_pkg::UP_RESET[7:6],
                                                 uep_pkg::UP_RESET[3:0]};
         {addr_en, addr_val} <= uep_pkg::ADDR_RESET;
         for (int i = 0; i < 5; i++) begin
            mode[i] <= uep_pkg::MODE_DISABLE;
            cnt[i]  <= uep_pkg::COUNT_RESET;
         end
         ack           <= 5'h00;
         stall         <= 5'h00;
         tok           <= 3'h0;
         ep0_lock      <= 1'b0;
         setup_busy    <= 1'b0;
         setup_block   <= 1'b0;
         io_rdata      <= 8'h00;
         ram_wr_en     <= 1'b0;
         ram_wr_addr_q <= 8'h00;
         ram_wr_data_q <= 8'h00;
         addr_match_en <= 1'b0;
         dev_addr      <= 7'h00;
         dp_meta       <= 1'b0;
         dm_meta       <= 1'b0;
         line_dp       <= 1'b0;
         line_dm       <= 1'b0;
      end else begin
         up_size       <= next_up_size;
         up_five       <= next_up_five;
         up_act        <= next_up_act;
         up_ctrl       <= next_up_ctrl;
         addr_en       <= next_addr_en;
         addr_val      <= next_addr_val;
         mode          <= next_mode;
         cnt           <= next_cnt;
         ack           <= next_ack;
         stall         <= next_stall;
         tok           <= next_tok;
         ep0_lock      <= next_ep0_lock;
         setup_busy    <= next_setup_busy;
         setup_block   <= next_setup_block;
         io_rdata      <= next_rdata;
         ram_wr_en     <= next_ram_en;
         ram_wr_addr_q <= ram_wr_addr;
         ram_wr_data_q <= ram_wr_data;
         addr_match_en <= next_addr_en;
         dev_addr      <= next_addr_val;
         dp_meta       <= dp_i;                             // two-flop sync
         dm_meta       <= dm_i;
         line_dp       <= dp_meta;
         line_dm       <= dm_meta;
      end
   end

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   sequence s_setup_open;
      se_setup_start ##1 (setup_busy && !se_ack_start);
   endsequence

   chk_activity_set: assert property (se_bus_activity |=> up_act)
      else $error("activity flag not set");
   chk_activity_clear: assert property (port_write && io_addr == uep_pkg::ADDR_UPSTREAM
      && !io_wdata[3] && !se_bus_activity |=> !up_act)
      else $error("activity flag not cleared");
   chk_release_drive: assert property (up_ctrl == uep_pkg::FORCE_NONE
      |=> dp_oe == $past(se_oe) && dp_o == $past(se_dp_o))
      else $error("engine drive not passed through");
   chk_force_j: assert property (up_ctrl == uep_pkg::FORCE_J
      |=> dp_o && dp_oe && !dm_o && dm_oe)
      else $error("force J wrong");
   chk_float_both: assert property (up_ctrl == uep_pkg::FORCE_FLOAT
      |=> !dp_oe && !dm_oe)
      else $error("float not applied");
   chk_reset_clear: assert property ($fell(srst) |-> !up_act && up_ctrl == 3'h0
      && !addr_match_en && mode[0] == 4'h0)
      else $error("reset values wrong");
   chk_addr_load: assert property (port_write && io_addr == uep_pkg::ADDR_FUNC_ADDR
      |=> addr_match_en == $past(io_wdata[7]) && dev_addr == $past(io_wdata[6:0]))
      else $error("address not loaded");
   chk_setup_hold: assert property (s_setup_open |-> tok[2])
      else $error("setup flag dropped");
   // whole data phase, not only its first cycle
   chk_setup_busy: assert property (setup_busy |-> tok[2] && setup_block)
      else $error("setup flag cleared during data phase");
   chk_ep0_lock: assert property (ep0_lock && port_write && io_addr == uep_pkg::ADDR_MODE_A
      && !se_txn_done |=> mode[0] == $past(mode[0]))
      else $error("locked mode written");
   chk_ram_guard: assert property (ram_wr_req && in_ep0_buf && tok[2] |=> !ram_wr_en)
      else $error("ep0 buffer write passed");
   chk_ack_nak: assert property (ev_ok && se_txn_acked && se_txn_pid == uep_pkg::PID_OUT
      && mode[se_txn_ep] == 4'h9 |=> ack[$past(se_txn_ep)]
      && mode[$past(se_txn_ep)] == 4'h8)
      else $error("ack mode not dropped to nak");
   chk_setup_nak: assert property (ev_ok && se_txn_pid == uep_pkg::PID_SETUP
      && mode[se_txn_ep] != 4'h0 |=> mode[$past(se_txn_ep)] == 4'h1)
      else $error("setup did not force nak");
endmodule // uep_ctrl

// ---- src/uep_pkg.sv ----
// constants shared by the endpoint and upstream port control logic
package uep_pkg;
   // port register offsets
   localparam logic [7:0] ADDR_FUNC_ADDR = 8'h10;
   localparam logic [7:0] ADDR_COUNT_A   = 8'h11;
   localparam logic [7:0] ADDR_MODE_A    = 8'h12;
   localparam logic [7:0] ADDR_COUNT_B   = 8'h13;
   localparam logic [7:0] ADDR_MODE_B    = 8'h14;
   localparam logic [7:0] ADDR_COUNT_C   = 8'h15;
   localparam logic [7:0] ADDR_MODE_C    = 8'h16;
   localparam logic [7:0] ADDR_UPSTREAM  = 8'h1F;
   localparam logic [7:0] ADDR_COUNT_D   = 8'h41;
   localparam logic [7:0] ADDR_MODE_D    = 8'h42;
   localparam logic [7:0] ADDR_COUNT_E   = 8'h43;
   localparam logic [7:0] ADDR_MODE_E    = 8'h44;
   // upstream register field positions
   localparam int UP_SIZE_BIT = 7;
   localparam int UP_FIVE_BIT = 6;
   localparam int UP_DP_BIT   = 5;
   localparam int UP_DM_BIT   = 4;
   localparam int UP_ACT_BIT  = 3;
   // mode register field positions
   localparam int MD_TOP_BIT  = 7;
   localparam int MD_ACK_BIT  = 4;
   // reset values
   localparam logic [7:0] UP_RESET    = 8'h00;
   localparam logic [7:0] ADDR_RESET  = 8'h00;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   // endpoint mode codes
   localparam logic [3:0] MODE_DISABLE  = 4'h0;
   localparam logic [3:0] MODE_NAK_BOTH = 4'h1;
   // line forcing codes
   localparam logic [2:0] FORCE_NONE  = 3'h0;
   localparam logic [2:0] FORCE_J     = 3'h1;
   localparam logic [2:0] FORCE_K     = 3'h2;
   localparam logic [2:0] FORCE_SE0   = 3'h3;
   localparam logic [2:0] FORCE_LOW   = 3'h4;
   localparam logic [2:0] FORCE_DPZ   = 3'h5;
   localparam logic [2:0] FORCE_DMZ   = 3'h6;
   localparam logic [2:0] FORCE_FLOAT = 3'h7;
   // token kinds reported by the serial engine
   localparam logic [1:0] PID_SETUP = 2'h0;
   localparam logic [1:0] PID_IN    = 2'h1;
   localparam logic [1:0] PID_OUT   = 2'h2;
   // fifo bases: small layout, large layout
   localparam logic [7:0] FIFO_S0 = 8'hF8, FIFO_S1 = 8'hF0, FIFO_S2 = 8'hE8;
   localparam logic [7:0] FIFO_S3 = 8'hE0, FIFO_S4 = 8'hD8;
   localparam logic [7:0] FIFO_L0 = 8'hB8, FIFO_L1 = 8'hC0, FIFO_L2 = 8'hE0;
   localparam logic [7:0] FIFO_L3 = 8'hB0, FIFO_L4 = 8'hA8;
endpackage

// ---- src/uep_line_drive.sv ----
// upstream line forcing: engine drive or forced levels
`timescale 1ns/1ps
module uep_line_drive (
   input  wire logic       clk_sys,
   input  wire logic       srst,
   input  wire logic [2:0] force_code,  // control bits 2:0
   input  wire logic       se_dp_o,     // engine drive values
   input  wire logic       se_dm_o,
   input  wire logic       se_oe,
   output logic            dp_o,
   output logic            dp_oe,
   output logic            dm_o,
   output logic            dm_oe
);
   logic [3:0] next_drv;  // {dp_o, dp_oe, dm_o, dm_oe}

   // decode the force code into pin drive
   always_comb begin
      case (force_code)
         uep_pkg::FORCE_NONE:  next_drv = {se_dp_o, se_oe, se_dm_o, se_oe};
         uep_pkg::FORCE_J:     next_drv = 4'hD;
         uep_pkg::FORCE_K:     next_drv = 4'h7;
         uep_pkg::FORCE_SE0:   next_drv = 4'h5;
         uep_pkg::FORCE_LOW:   next_drv = 4'h5;
         uep_pkg::FORCE_DPZ:   next_drv = 4'h1;
         uep_pkg::FORCE_DMZ:   next_drv = 4'h4;
         default:              next_drv = 4'h0;
      endcase
   end

   // registered so pins change cleanly
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         {dp_o, dp_oe, dm_o, dm_oe} <= 4'h0;
      end else begin
         {dp_o, dp_oe, dm_o, dm_oe} <= next_drv;
      end
   end
endmodule // uep_line_drive

// ---- src/uep_fifo_map.sv ----
// endpoint fifo placement in data ram
`timescale 1ns/1ps
module uep_fifo_map (
   input  wire logic        clk_sys,
   input  wire logic        srst,
   input  wire logic        size_sel,   // large layout
   input  wire logic        five_sel,   // five endpoints
   output logic [39:0]      fifo_base,  // endpoint n at [8n+7:8n]
   output logic [4:0]       fifo_active
);
   logic [39:0] next_base;
   logic [4:0]  next_active;

   // pick the base table
   always_comb begin
      if (size_sel) begin
         next_base = {uep_pkg::FIFO_L4, uep_pkg::FIFO_L3, uep_pkg::FIFO_L2,
                      uep_pkg::FIFO_L1, uep_pkg::FIFO_L0};
      end else begin
         next_base = {uep_pkg::FIFO_S4, uep_pkg::FIFO_S3, uep_pkg::FIFO_S2,
                      uep_pkg::FIFO_S1, uep_pkg::FIFO_S0};
      end
      // areas three and four stay plain ram unless five chosen
      next_active = five_sel ? 5'h1F : 5'h07;
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         fifo_base   <= 40'h0;
         fifo_active <= 5'h07;
      end else begin
         fifo_base   <= next_base;
         fifo_active <= next_active;
      end
   end
endmodule // uep_fifo_map

// ---- dv/uep_host_model.sv ----
// host side of the upstream port: resolved D+ and D- levels
`timescale 1ns/1ps
module uep_host_model (
   input  wire logic dp_o,
   input  wire logic dp_oe,
   input  wire logic dm_o,
   input  wire logic dm_oe,
   output logic      dp_i,
   output logic      dm_i
);
   // a released D+ rests high on the device pull-up
   assign dp_i = dp_oe ? dp_o : 1'b1;
   // a released D- rests low on the host pull-down
   assign dm_i = dm_oe ? dm_o : 1'b0;
endmodule // uep_host_model

// ---- dv/tb_top.sv ----
// self-checking bench for the endpoint and upstream port control block
`timescale 1ns/1ps
module tb_top;
   logic        clk_sys, srst, port_read, port_write, ram_wr_req, ram_wr_en;
   logic        se_dp_o, se_dm_o, se_oe, se_bus_activity, se_setup_start, se_ack_start;
   logic        se_ep0_rx_active, se_txn_done, se_txn_acked, se_rx_toggle;
   logic        dp_i, dm_i, dp_o, dp_oe, dm_o, dm_oe, addr_match_en, line_dp, line_dm;
   logic [7:0]  io_addr, io_wdata, io_rdata, ram_wr_addr, ram_wr_data;
   logic [7:0]  ram_wr_addr_q, ram_wr_data_q;
   logic [2:0]  se_txn_ep;
   logic [1:0]  se_txn_pid;
   logic [5:0]  se_rx_count;
   logic [6:0]  dev_addr;
   logic [19:0] ep_mode_flat;
   logic [4:0]  ep_stall, ep_toggle, ep_fifo_active;
   logic [39:0] ep_fifo_base;
   int          err_count, num_checks;
   // pin rows per forcing code: oe_p, drv_p, oe_m, drv_m
   logic [3:0]  pin_tab [8] = '{4'hE, 4'hE, 4'hB, 4'hA, 4'hA, 4'h2, 4'h8, 4'h0};
   logic [3:0]  t;

   uep_ctrl uut (.*);
   uep_host_model host (.*);

   // free-running system clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic chk(string nm, logic [47:0] seen, logic [47:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // one-cycle port write, launched off the falling edge
   task automatic wr(logic [7:0] a, logic [7:0] d);
      io_addr = a;
      io_wdata = d;
      port_write = 1'b1;
      @(negedge clk_sys);
      port_write = 1'b0;
   endtask

   // read data lands one edge after the strobe and then stands
   task automatic rd(logic [7:0] a, logic [7:0] e, string nm);
      io_addr = a;
      port_read = 1'b1;
      @(negedge clk_sys);
      port_read = 1'b0;
      @(negedge clk_sys);
      chk(nm, io_rdata, e);
   endtask

   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk_sys);
      s = 1'b0;
   endtask

   // acked transaction end from the serial engine
   task automatic txn(logic [2:0] ep, logic [1:0] pid);
      {se_txn_ep, se_txn_pid, se_txn_done, se_txn_acked} = {ep, pid, 2'b11};
      @(negedge clk_sys);
      {se_txn_done, se_txn_acked} = 2'b00;
   endtask

   // gated ram write; the enable pulse may sit in either of two cycles
   task automatic ram(logic [7:0] a, logic e);
      logic g;
      ram_wr_addr = a;
      ram_wr_data = 8'h5A;
      ram_wr_req = 1'b1;
      @(negedge clk_sys);
      ram_wr_req = 1'b0;
      g = ram_wr_en;
      chk("ram data", {ram_wr_addr_q, ram_wr_data_q}, {a, 8'h5A});
      @(negedge clk_sys);
      chk("ram write", g | ram_wr_en, e);
   endtask

   // hang guard, counted as a mismatch
   initial begin
      #200us;
      err_count++;
      finish_test();
   end

   initial begin
      {port_read, port_write, ram_wr_req, se_dp_o, se_dm_o, se_bus_activity} = '0;
      {se_setup_start, se_ack_start, se_ep0_rx_active, se_txn_done, se_txn_acked} = '0;
      {io_addr, io_wdata, ram_wr_addr, ram_wr_data, se_txn_ep, se_txn_pid} = '0;
      {se_rx_count, se_rx_toggle, se_oe} = '0;
      srst = 1'b1;
      repeat (12) @(negedge clk_sys);
      srst = 1'b0;
      // line levels need two edges through the synchroniser
      repeat (2) @(negedge clk_sys);
      chk("modes", ep_mode_flat, 48'h0);
      rd(8'h1F, 8'h20, "upstream");
      rd(8'h10, 8'h00, "address");
      chk("fifo", {ep_fifo_active, ep_fifo_base}, {5'h07, 40'hD8E0E8F0F8});
      // engine drives J while nothing is forced
      {se_oe, se_dp_o, se_dm_o} = 3'b110;
      for (int c = 0; c < 8; c++) begin
         t = pin_tab[c];
         wr(8'h1F, {5'h00, c[2:0]});
         repeat (3) @(negedge clk_sys);
         chk("pins", {dp_oe, dp_o & dp_oe, dm_oe, dm_o & dm_oe}, t);
         repeat (3) @(negedge clk_sys);
         rd(8'h1F, {2'b00, t[3] ? t[2] : 1'b1, t[1] & t[0], 1'b0, c[2:0]}, "lines");
      end
      wr(8'h1F, 8'hC0);
      repeat (2) @(negedge clk_sys);
      chk("fifo", {ep_fifo_active, ep_fifo_base}, {5'h1F, 40'hA8B0E0C0B8});
      wr(8'h1F, 8'h00);
      pulse(se_bus_activity);
      wr(8'h1F, 8'h08);
      rd(8'h1F, 8'h28, "activity");
      wr(8'h1F, 8'h00);
      rd(8'h1F, 8'h20, "activity");
      wr(8'h10, 8'h85);
      @(negedge clk_sys);
      chk("address", {addr_match_en, dev_addr}, 8'h85);
      // acked OUT on endpoint 0, then a write that the lock must refuse
      wr(8'h12, 8'h0B);
      {se_rx_count, se_rx_toggle} = {6'h03, 1'b1};
      txn(3'h0, 2'h2);
      wr(8'h12, 8'h00);
      rd(8'h12, 8'h3A, "ep0 mode");
      rd(8'h11, 8'hC3, "ep0 count");
      chk("toggle", ep_toggle[0], 1'b1);
      wr(8'h12, 8'h00);
      rd(8'h12, 8'h00, "ep0 mode");
      // setup flag holds until the first read, and blocks buffer writes
      pulse(se_setup_start);
      ram(8'hF9, 1'b0);
      pulse(se_ack_start);
      wr(8'h12, 8'h00);
      rd(8'h12, 8'h80, "setup flag");
      wr(8'h12, 8'h00);
      rd(8'h12, 8'h00, "setup flag");
      ram(8'hF9, 1'b1);
      se_ep0_rx_active = 1'b1;
      ram(8'hF9, 1'b0);
      se_ep0_rx_active = 1'b0;
      // acked IN on endpoint one with stall set
      wr(8'h14, 8'h8D);
      chk("stall", ep_stall, 5'h02);
      txn(3'h1, 2'h1);
      rd(8'h14, 8'h9C, "ep1 mode");
      // reserved bits 6:5 are dropped on write and read back as zero
      wr(8'h14, 8'hED);
      rd(8'h14, 8'h8D, "ep1 reserved");
      chk("ep1 mode", ep_mode_flat[7:4], 4'hD);
      // endpoint three is absent in three-endpoint mode
      txn(3'h3, 2'h1);
      rd(8'h42, 8'h00, "ep3 refused");
      // acked setup on endpoint two forces the nak code
      wr(8'h16, 8'h02);
      txn(3'h2, 2'h0);
      rd(8'h16, 8'h11, "ep2 setup");
      rd(8'h15, 8'hC3, "ep2 count");
      // acked OUT in ack-out mode drops to nak-out
      wr(8'h14, 8'h09);
      txn(3'h1, 2'h2);
      rd(8'h14, 8'h18, "ep1 ack out");
      // second reset in mid-run clears what was set above
      srst = 1'b1;
      repeat (2) @(negedge clk_sys);
      srst = 1'b0;
      repeat (2) @(negedge clk_sys);
      rd(8'h1F, 8'h20, "upstream");
      rd(8'h14, 8'h00, "ep1 mode");
      rd(8'h10, 8'h00, "address");
      finish_test();
   end
endmodule // tb_top
